// [design/cmc_pkg.sv]
/*
  Shared constants of the CAN operating-mode controller: register offsets,
  field positions, mode codes, reset values and timing figures.
  Assumes a 25 MHz module clock and a 32-bit classic Wishbone register bus.
*/
`default_nettype none

package cmc_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS   = 40;
  localparam int WAKE_FILT_NS    = 200;  // Least glitch width the wake filter passes
  localparam int WAKE_FILT_CYC   = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_BITS       = 11;   // Recessive bits that make the bus idle

  // ==========================================================================
  // Mode codes, shared by the request and current-mode fields
  // ==========================================================================
  typedef enum logic [2:0] {
    CMC_MODE_NORMAL  = 3'h0,
    CMC_MODE_DISABLE = 3'h1,
    CMC_MODE_LOOP    = 3'h2,
    CMC_MODE_LISTEN  = 3'h3,
    CMC_MODE_CONFIG  = 3'h4,
    CMC_MODE_RSV5    = 3'h5,
    CMC_MODE_RSV6    = 3'h6,
    CMC_MODE_LSNALL  = 3'h7
  } cmc_mode_e;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL1   = 8'h00;  // module_control_one
  localparam logic [7:0] OFS_CFG2    = 8'h04;  // bit_timing_config_two
  localparam logic [7:0] OFS_BAUD    = 8'h08;  // Baud rate configuration
  localparam logic [7:0] OFS_FILT    = 8'h0C;  // Acceptance filter
  localparam logic [7:0] OFS_AMSK    = 8'h10;  // Acceptance mask
  localparam logic [7:0] OFS_IRQ_ST  = 8'h14;  // Interrupt status, read clears
  localparam logic [7:0] OFS_IRQ_MSK = 8'h18;  // Interrupt mask
  localparam logic [7:0] OFS_TXCTL   = 8'h1C;  // Transmit request / abort

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTRL_REQ_LSB    = 8;   // mode_request_field 10:8
  localparam int CTRL_CUR_LSB    = 5;   // current_mode_field 7:5
  localparam int CTRL_ABORT_BIT  = 12;  // Abort all pending transmissions
  localparam int CFG2_WAKE_FILTER_ENABLE_BIT = 14;  // wake_filter_enable
  localparam int CFG2_W          = 15;
  localparam int TX_REQ_BIT      = 0;   // tx_request_flag
  localparam int TX_ABT_BIT      = 1;   // tx_aborted_flag
  localparam int IRQ_WAKE_BIT    = 0;
  localparam int IRQ_ABT_BIT     = 1;
  localparam int IRQ_MODE_BIT    = 2;
  localparam int IRQ_W           = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [CFG2_W-1:0] CFG2_RST  = 15'h0000;
  localparam logic [31:0]       WORD_ZERO = 32'h0000_0000;
  localparam logic [IRQ_W-1:0]  IRQ_ZERO  = 3'h0;

endpackage : cmc_pkg

`default_nettype wire

// [design/cmc_mode_ctrl.sv]
/*
  Operating-mode controller of a CAN node: mode request and current mode,
  bus-idle detection, configuration lock, pin ownership, loopback, wake
  filter and wake flag, transmit start gating and abort.
  Assumes a bit-timing engine on the same clock that pulses bit_tick_i at
  each sample point, and a protocol engine that drives core_tx_i and reports
  core_tx_busy_i while a frame is on the wire.
*/
// Register access over Wishbone and the register addresses were decided locally.
// How it works
// RQ1: Request field written, current mode field read back
// RQ2: Mode changes only after eleven recessive bits
// RQ3: Configuration: no traffic, error counters cleared
// RQ4: Configuration registers writable only in configuration
// RQ5: Configuration entry waits for transmission end
// RQ6: Disable: no traffic, wake flag, counters kept
// RQ7: Request 001 enters disable after idle bus
// RQ8: Disable releases both bus pins
// RQ9: Wake filter on receive, enabled by bit 14
// RQ10: New transmit waits for eleven recessive bits
// RQ11: Disable during that wait aborts the transmit
// RQ12: Request 000: normal mode, pins owned, full traffic
// RQ13: Listen-only: passive, transmit pin released, counters off
// RQ14: Request 111: ignore errors, keep partial frames
// RQ15: Loopback joins transmit to receive, pins released
// RQ16: Dominant bit restarts the idle counter
// RQ17: Distinct codes; reserved requests are ignored
`timescale 1ns/1ps
`default_nettype none

module cmc_mode_ctrl #(
  parameter int IDLE_BITS_P = cmc_pkg::IDLE_BITS,
  parameter int WAKE_CYC_P  = cmc_pkg::WAKE_FILT_CYC
) (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt
  output logic             irq_o,
  // Bus pins
  input  wire logic        bus_receive_pin_i,
  output logic             bus_transmit_pin_o,
  output logic             bus_transmit_pin_oe_o,
  output logic             bus_receive_pin_own_o,
  // Protocol engine side
  input  wire logic        bit_tick_i,
  input  wire logic        core_tx_i,
  input  wire logic        core_tx_busy_i,
  input  wire logic        cpu_sleep_i,
  output logic             core_rx_o,
  output logic             core_tx_start_o,
  output logic             core_tx_en_o,
  output logic             core_rx_en_o,
  output logic             core_ack_err_en_o,
  output logic             core_accept_all_o,
  output logic             err_cnt_clear_o,
  output logic             err_cnt_hold_o,
  // Configuration toward the engine
  output logic [14:0]      bit_timing_cfg_o,
  output logic [31:0]      baud_cfg_o,
  output logic [31:0]      accept_filter_o,
  output logic [31:0]      accept_mask_o
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam logic [3:0] IDLE_MAX = 4'(IDLE_BITS_P);
  localparam logic [3:0] WAKE_MAX = 4'(WAKE_CYC_P);

  cmc_pkg::cmc_mode_e req_ff, cur_ff;
  logic [3:0]         idle_cnt_ff;
  logic               rx_meta_ff, rx_sync_ff;
  logic [3:0]         filt_cnt_ff;
  logic               rx_filt_ff, rx_prev_ff;
  logic               core_rx_ff, tx_pin_ff;
  logic               fresh_ff;
  logic               tx_req_ff, tx_abt_ff, abort_all_ff;
  logic [14:0]        cfg2_ff;
  logic [31:0]        baud_ff, filt_ff, amsk_ff;
  logic [2:0]         irq_st_ff, irq_msk_ff;
  logic               ack_ff;
  logic [31:0]        rdat_ff;

  logic               bus_idle, mode_go, tx_start, tx_abort, wake_evt;
  logic               wr_stb, rd_stb, cfg_ok, tx_mode, rx_line, filt_on;
  logic [2:0]         wreq;
  logic [31:0]        nxt_rdat;

  // ==========================================================================
  // Wishbone strobes
  // ==========================================================================
  // One wait state: ack comes the cycle after the request is seen
  assign wr_stb = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i;  // Writes land at the acknowledged edge
  assign rd_stb = wb_cyc_i & wb_stb_i & ~ack_ff & ~wb_we_i;
  assign cfg_ok = (cur_ff == cmc_pkg::CMC_MODE_CONFIG);  // [RQ4]
  assign wreq   = wb_dat_i[cmc_pkg::CTRL_REQ_LSB +: 3];

  // Ack register, dropped the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
    end
  end

  // ==========================================================================
  // Receive input path
  // ==========================================================================
  // Two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end else if (ce_i) begin
      rx_meta_ff <= bus_receive_pin_i;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  // Low-pass only while asleep or disabled, so normal bit timing is untouched
  assign filt_on = cfg2_ff[cmc_pkg::CFG2_WAKE_FILTER_ENABLE_BIT] &
                   (cpu_sleep_i | (cur_ff == cmc_pkg::CMC_MODE_DISABLE));  // [RQ9]

  // Filtered line follows the pin after a stable run while the filter is on, and at once while it is off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_cnt_ff <= 4'h0;
      rx_filt_ff  <= 1'b1;
    end else if (ce_i) begin
      if (!filt_on || rx_sync_ff == rx_filt_ff) begin
        filt_cnt_ff <= 4'h0;
        if (!filt_on) begin
          rx_filt_ff <= rx_sync_ff;
        end
      end else if (filt_cnt_ff + 4'h1 >= WAKE_MAX) begin  // [RQ9]
        filt_cnt_ff <= 4'h0;
        rx_filt_ff  <= rx_sync_ff;
      end else begin
        filt_cnt_ff <= filt_cnt_ff + 4'h1;
      end
    end
  end

  // Line the engine and idle detector see; loopback ignores the pin
  assign rx_line = (cur_ff == cmc_pkg::CMC_MODE_LOOP) ? core_tx_i : rx_filt_ff;  // [RQ15]

  // Registered engine receive and pin drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_rx_ff <= 1'b1;
      tx_pin_ff  <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else if (ce_i) begin
      core_rx_ff <= rx_line;
      tx_pin_ff  <= core_tx_i;
      rx_prev_ff <= rx_filt_ff;
    end
  end

  // Falling edge of the filtered line in disable mode is bus activity
  assign wake_evt = (cur_ff == cmc_pkg::CMC_MODE_DISABLE) & rx_prev_ff & ~rx_filt_ff;  // [RQ6]

  // ==========================================================================
  // Bus idle detector
  // ==========================================================================
  // Counts recessive samples, saturating at the idle threshold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_ff <= 4'h0;
    end else if (ce_i && bit_tick_i) begin
      if (!rx_line) begin
        idle_cnt_ff <= 4'h0;  // [RQ16]
      end else if (idle_cnt_ff < IDLE_MAX) begin
        idle_cnt_ff <= idle_cnt_ff + 4'h1;
      end
    end
  end

  assign bus_idle = (idle_cnt_ff >= IDLE_MAX);  // [RQ2]

  // ==========================================================================
  // Mode sequencing
  // ==========================================================================
  // Change when idle; configuration also waits for the frame to end
  assign mode_go = (req_ff != cur_ff) & bus_idle &
                   ~((req_ff == cmc_pkg::CMC_MODE_CONFIG) & core_tx_busy_i);  // [RQ2] [RQ5] [RQ7]

  // Request field; reserved codes leave the old request in place
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_ff <= cmc_pkg::CMC_MODE_CONFIG;
    end else if (ce_i && wr_stb && wb_adr_i == cmc_pkg::OFS_CTRL1 && wb_sel_i[1]) begin
      if (wreq != cmc_pkg::CMC_MODE_RSV5 && wreq != cmc_pkg::CMC_MODE_RSV6) begin  // [RQ17]
        req_ff <= cmc_pkg::cmc_mode_e'(wreq);  // [RQ1]
      end
    end
  end

  // Current mode, only moved by an accepted change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ff <= cmc_pkg::CMC_MODE_CONFIG;
    end else if (ce_i && mode_go) begin
      cur_ff <= req_ff;  // [RQ1] [RQ7] [RQ12]
    end
  end

  // Transmitting modes can originate frames
  assign tx_mode = (cur_ff == cmc_pkg::CMC_MODE_NORMAL) | (cur_ff == cmc_pkg::CMC_MODE_LOOP);

  // Marks the first idle wait after entering a transmitting mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fresh_ff <= 1'b0;
    end else if (ce_i) begin
      if (mode_go) begin
        fresh_ff <= (req_ff == cmc_pkg::CMC_MODE_NORMAL) | (req_ff == cmc_pkg::CMC_MODE_LOOP);
      end else if (tx_start) begin
        fresh_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Transmit request, start and abort
  // ==========================================================================
  // Idle gate on every start covers the wait after mode entry
  assign tx_start = tx_req_ff & tx_mode & bus_idle & ~core_tx_busy_i &
                    ~abort_all_ff & ~(req_ff == cmc_pkg::CMC_MODE_DISABLE);  // [RQ10]
  assign tx_abort = tx_req_ff & ~core_tx_busy_i &
                    ((fresh_ff & (req_ff == cmc_pkg::CMC_MODE_DISABLE)) | abort_all_ff);  // [RQ11]

  // Request set by software, cleared by start or abort
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_req_ff <= 1'b0;
    end else if (ce_i) begin
      if (tx_start || tx_abort) begin
        tx_req_ff <= 1'b0;  // [RQ11]
      end else if (wr_stb && wb_adr_i == cmc_pkg::OFS_TXCTL && wb_sel_i[0]) begin
        tx_req_ff <= wb_dat_i[cmc_pkg::TX_REQ_BIT];
      end
    end
  end

  // Abort flag; a new request clears it, an abort in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_abt_ff <= 1'b0;
    end else if (ce_i) begin
      if (tx_abort) begin
        tx_abt_ff <= 1'b1;  // [RQ11]
      end else if (wr_stb && wb_adr_i == cmc_pkg::OFS_TXCTL && wb_sel_i[0] &&
                   wb_dat_i[cmc_pkg::TX_REQ_BIT]) begin
        tx_abt_ff <= 1'b0;
      end
    end
  end

  // Abort-all command, self-clearing once nothing is pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      abort_all_ff <= 1'b0;
    end else if (ce_i) begin
      if (wr_stb && wb_adr_i == cmc_pkg::OFS_CTRL1 && wb_sel_i[1] &&
          wb_dat_i[cmc_pkg::CTRL_ABORT_BIT]) begin
        abort_all_ff <= 1'b1;
      end else if (!tx_req_ff) begin
        abort_all_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Locked configuration registers
  // ==========================================================================
  // Writes while on-line are dropped silently but still acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg2_ff    <= cmc_pkg::CFG2_RST;
      baud_ff    <= cmc_pkg::WORD_ZERO;
      filt_ff    <= cmc_pkg::WORD_ZERO;
      amsk_ff    <= cmc_pkg::WORD_ZERO;
      irq_msk_ff <= cmc_pkg::IRQ_ZERO;
    end else if (ce_i && wr_stb && cfg_ok) begin  // [RQ4]
      case (wb_adr_i)
        cmc_pkg::OFS_CFG2: begin
          if (wb_sel_i[0]) cfg2_ff[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cfg2_ff[14:8] <= wb_dat_i[14:8];
        end
        cmc_pkg::OFS_BAUD:    baud_ff    <= wb_dat_i;
        cmc_pkg::OFS_FILT:    filt_ff    <= wb_dat_i;
        cmc_pkg::OFS_AMSK:    amsk_ff    <= wb_dat_i;
        cmc_pkg::OFS_IRQ_MSK: irq_msk_ff <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Interrupt status
  // ==========================================================================
  // Read clears; an event in the same cycle as the clearing read survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_ff <= cmc_pkg::IRQ_ZERO;
    end else if (ce_i) begin
      irq_st_ff <= (rd_stb && wb_adr_i == cmc_pkg::OFS_IRQ_ST) ? cmc_pkg::IRQ_ZERO : irq_st_ff;
      if (wake_evt) irq_st_ff[cmc_pkg::IRQ_WAKE_BIT] <= 1'b1;  // [RQ6]
      if (tx_abort) irq_st_ff[cmc_pkg::IRQ_ABT_BIT]  <= 1'b1;
      if (mode_go)  irq_st_ff[cmc_pkg::IRQ_MODE_BIT] <= 1'b1;
    end
  end

  assign irq_o = |(irq_st_ff & irq_msk_ff);

  // ==========================================================================
  // Read data
  // ==========================================================================
  // Read mux, registered with the ack; unmapped reads give zero
  always_comb begin
    nxt_rdat = cmc_pkg::WORD_ZERO;
    case (wb_adr_i)
      cmc_pkg::OFS_CTRL1: begin
        nxt_rdat[cmc_pkg::CTRL_REQ_LSB +: 3] = req_ff;
        nxt_rdat[cmc_pkg::CTRL_CUR_LSB +: 3] = cur_ff;  // [RQ1]
        nxt_rdat[cmc_pkg::CTRL_ABORT_BIT]    = abort_all_ff;
      end
      cmc_pkg::OFS_CFG2:    nxt_rdat[14:0] = cfg2_ff;
      cmc_pkg::OFS_BAUD:    nxt_rdat = baud_ff;
      cmc_pkg::OFS_FILT:    nxt_rdat = filt_ff;
      cmc_pkg::OFS_AMSK:    nxt_rdat = amsk_ff;
      cmc_pkg::OFS_IRQ_ST:  nxt_rdat[2:0] = irq_st_ff;
      cmc_pkg::OFS_IRQ_MSK: nxt_rdat[2:0] = irq_msk_ff;
      cmc_pkg::OFS_TXCTL: begin
        nxt_rdat[cmc_pkg::TX_REQ_BIT] = tx_req_ff;
        nxt_rdat[cmc_pkg::TX_ABT_BIT] = tx_abt_ff;
      end
      default: nxt_rdat = cmc_pkg::WORD_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= cmc_pkg::WORD_ZERO;
    end else if (ce_i && rd_stb) begin
      rdat_ff <= nxt_rdat;
    end
  end

  // ==========================================================================
  // Per-mode effects
  // ==========================================================================
  // Configuration and disable stop all traffic
  assign core_tx_en_o      = tx_mode;                                          // [RQ3] [RQ6] [RQ12]
  assign core_rx_en_o      = (cur_ff == cmc_pkg::CMC_MODE_NORMAL) | (cur_ff == cmc_pkg::CMC_MODE_LOOP) |
                             (cur_ff == cmc_pkg::CMC_MODE_LISTEN) | (cur_ff == cmc_pkg::CMC_MODE_LSNALL);
  // Listen modes never drive acknowledge or error frames
  assign core_ack_err_en_o = tx_mode;                                          // [RQ13]
  assign core_accept_all_o = (cur_ff == cmc_pkg::CMC_MODE_LSNALL);             // [RQ14]
  assign err_cnt_clear_o   = (cur_ff == cmc_pkg::CMC_MODE_CONFIG);             // [RQ3]
  assign err_cnt_hold_o    = (cur_ff == cmc_pkg::CMC_MODE_DISABLE) |
                             (cur_ff == cmc_pkg::CMC_MODE_LISTEN) |
                             (cur_ff == cmc_pkg::CMC_MODE_LSNALL);             // [RQ6] [RQ13]
  assign core_tx_start_o   = tx_start & ce_i;

  // Pin ownership; released pins fall back to the port logic
  assign bus_transmit_pin_oe_o = (cur_ff == cmc_pkg::CMC_MODE_NORMAL);        // [RQ8] [RQ12] [RQ13] [RQ15]
  assign bus_receive_pin_own_o = (cur_ff == cmc_pkg::CMC_MODE_NORMAL) |
                                 (cur_ff == cmc_pkg::CMC_MODE_LISTEN) |
                                 (cur_ff == cmc_pkg::CMC_MODE_LSNALL);         // [RQ8] [RQ15]
  assign bus_transmit_pin_o    = tx_pin_ff;
  assign core_rx_o             = core_rx_ff;

  // Configuration toward the engine
  assign bit_timing_cfg_o = cfg2_ff;
  assign baud_cfg_o       = baud_ff;
  assign accept_filter_o  = filt_ff;
  assign accept_mask_o    = amsk_ff;
  assign wb_dat_o         = rdat_ff;
  assign wb_ack_o         = ack_ff;

endmodule // cmc_mode_ctrl

`default_nettype wire

// [tb/cmc_bus_node.sv]
/*
  Far side of the bus: other CAN nodes on a wired-AND line.
  Assumes the bench asks for dominant bits through drive_dom_i.
*/
`timescale 1ns/1ps
`default_nettype none
module cmc_bus_node (
  // Our node's transmit pin
  input  wire logic tx_i,
  input  wire logic tx_oe_i,
  // Other nodes
  input  wire logic drive_dom_i,
  output logic      rx_o
);
  // A released pin floats recessive through the termination
  assign rx_o = (tx_oe_i ? tx_i : 1'b1) & !drive_dom_i;
endmodule // cmc_bus_node
`default_nettype wire

// [tb/cmc_mode_ctrl_monitor.sv]
/*
  Checker of the mode controller, bound to its top module.
  Assumes ce_i stays high and the line only changes away from bit ticks.
*/
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_ctrl_monitor #(
  parameter int IDLE_BITS_P = 11,
  parameter int WAKE_CYC_P  = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic bus_receive_pin_i,
  input wire logic bus_transmit_pin_o,
  input wire logic bus_transmit_pin_oe_o,
  input wire logic bus_receive_pin_own_o,
  input wire logic bit_tick_i,
  input wire logic core_tx_i,
  input wire logic core_tx_busy_i,
  input wire logic core_rx_o,
  input wire logic core_tx_start_o,
  input wire logic core_tx_en_o,
  input wire logic core_rx_en_o,
  input wire logic core_accept_all_o,
  input wire logic err_cnt_clear_o,
  input wire logic err_cnt_hold_o
);
  logic [3:0] idle_ff;
  logic       d1_ff;
  logic       d2_ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Line as the design sees it, past its two-flop synchroniser
  always_ff @(posedge clk_i) begin
    d1_ff <= rst_i | bus_receive_pin_i;
    d2_ff <= rst_i | d1_ff;
  end
  // Recessive run length, saturating so it never wraps back to idle
  always_ff @(posedge clk_i) begin
    if (rst_i || (bit_tick_i && !d2_ff)) idle_ff <= 4'h0;
    else if (bit_tick_i && idle_ff != 4'hF) idle_ff <= idle_ff + 4'h1;
  end
  a_config_silent: assert property (err_cnt_clear_o |-> !core_tx_en_o && !core_rx_en_o)
    else $error("traffic enabled in configuration");
  a_pins_owned: assert property (bus_transmit_pin_oe_o |-> core_tx_en_o && bus_receive_pin_own_o)
    else $error("transmit pin owned outside normal");
  a_disable_free: assert property (err_cnt_hold_o && !core_rx_en_o |-> !bus_receive_pin_own_o && !core_tx_en_o)
    else $error("pins held in disable");
  a_listen_all: assert property (core_accept_all_o |-> core_rx_en_o && err_cnt_hold_o && !core_tx_en_o)
    else $error("listen-all not passive");
  a_loop_path: assert property (core_tx_en_o && !bus_transmit_pin_oe_o |=> core_rx_o == $past(core_tx_i))
    else $error("loopback path broken");
  a_tx_pin_copy: assert property (bus_transmit_pin_oe_o |=> bus_transmit_pin_o == $past(core_tx_i))
    else $error("transmit pin not following engine");
  a_mode_idle: assert property ($changed({core_rx_en_o, core_tx_en_o, err_cnt_hold_o, err_cnt_clear_o})
    |-> idle_ff >= IDLE_BITS_P)
    else $error("mode changed on busy bus");
  a_config_not_busy: assert property ($rose(err_cnt_clear_o) |-> !$past(core_tx_busy_i))
    else $error("configuration entered during transmission");
  a_start_idle: assert property (core_tx_start_o |-> idle_ff >= IDLE_BITS_P && core_tx_en_o ##1 !core_tx_start_o)
    else $error("transmit started before idle");
  c_start: cover property ($rose(core_tx_start_o));
  c_leave_cfg: cover property ($fell(err_cnt_clear_o));
  c_all: cover property (core_accept_all_o);
endmodule // cmc_mode_ctrl_monitor
bind cmc_mode_ctrl cmc_mode_ctrl_monitor #(.IDLE_BITS_P(IDLE_BITS_P), .WAKE_CYC_P(WAKE_CYC_P)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .bus_receive_pin_i(bus_receive_pin_i), .bus_transmit_pin_o(bus_transmit_pin_o),
  .bus_transmit_pin_oe_o(bus_transmit_pin_oe_o), .bus_receive_pin_own_o(bus_receive_pin_own_o),
  .bit_tick_i(bit_tick_i), .core_tx_i(core_tx_i), .core_tx_busy_i(core_tx_busy_i), .core_rx_o(core_rx_o),
  .core_tx_start_o(core_tx_start_o), .core_tx_en_o(core_tx_en_o), .core_rx_en_o(core_rx_en_o),
  .core_accept_all_o(core_accept_all_o), .err_cnt_clear_o(err_cnt_clear_o), .err_cnt_hold_o(err_cnt_hold_o));
`default_nettype wire

// [tb/tb.sv]
/*
  Testbench of the mode controller: idle, lock, abort and wake cases,
  then the mode table. Assumes the bus node model on the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, tick = 0, ctx = 1, busy = 0, dom = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, baud, q;
  logic ack, irq, rx, txp, oe, own, crx, start, txen, rxen, acken, all, clr, hold;
  logic [31:0] filt, amsk;
  logic [14:0] cfg;
  int bad_count = 0, comparisons = 0, starts = 0;
  wire logic [7:0] outs = {oe, own, txen, acken, rxen, all, hold, clr};
  // Mode code beside the outputs it must give
  logic [10:0] rows [6] = '{11'h0F8, 11'h238, 11'h34A, 11'h74E, 11'h102, 11'h401};
  cmc_bus_node node (.tx_i(txp), .tx_oe_i(oe), .drive_dom_i(dom), .rx_o(rx));
  cmc_mode_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
    .bus_receive_pin_i(rx), .bus_transmit_pin_o(txp), .bus_transmit_pin_oe_o(oe), .bus_receive_pin_own_o(own),
    .bit_tick_i(tick), .core_tx_i(ctx), .core_tx_busy_i(busy), .cpu_sleep_i(1'b0), .core_rx_o(crx),
    .core_tx_start_o(start), .core_tx_en_o(txen), .core_rx_en_o(rxen), .core_ack_err_en_o(acken),
    .core_accept_all_o(all), .err_cnt_clear_o(clr), .err_cnt_hold_o(hold), .bit_timing_cfg_o(cfg),
    .baud_cfg_o(baud), .accept_filter_o(filt), .accept_mask_o(amsk));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Counted mid-cycle, where the start pulse has settled
  always @(negedge clk_i) begin
    if (start === 1'b1) starts <= starts + 1;
  end
  task automatic give_verdict;
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // One classic cycle; a missing ack ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1; we <= w; adr <= a; wdat <= d;
    for (int i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
    q = rdat;
    cyc <= 0;
    if (ack !== 1'b1) begin
      bad_count++;
      give_verdict;
    end
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    chk(n, e, q);
  endtask
  // Line level first, settled past the synchroniser, then n bit ticks
  task automatic tk(input int n, input logic lvl);
    dom <= !lvl;
    repeat (4) @(posedge clk_i);
    repeat (n) begin
      tick <= 1; @(posedge clk_i);
      tick <= 0; @(posedge clk_i);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    rdc("ctrl", cmc_pkg::OFS_CTRL1, 32'h480);
    bus(1, cmc_pkg::OFS_BAUD, 32'h12345678);
    bus(1, cmc_pkg::OFS_CFG2, 32'h4000);
    bus(1, cmc_pkg::OFS_IRQ_MSK, 32'h6);
    bus(1, cmc_pkg::OFS_FILT, 32'hA5A50F0F);
    bus(1, cmc_pkg::OFS_AMSK, 32'h0000FFFF);
    bus(1, cmc_pkg::OFS_CTRL1, 32'h500);
    tk(12, 1);
    rdc("ctrl", cmc_pkg::OFS_CTRL1, 32'h480);
    tk(1, 0);
    bus(1, cmc_pkg::OFS_CTRL1, 32'h0);
    tk(10, 1);
    rdc("ctrl", cmc_pkg::OFS_CTRL1, 32'h080);
    tk(1, 0);
    tk(10, 1);
    rdc("ctrl", cmc_pkg::OFS_CTRL1, 32'h080);
    tk(1, 1);
    rdc("ctrl", cmc_pkg::OFS_CTRL1, 32'h0);
    chk("irq", 1, irq);
    rdc("irq_st", cmc_pkg::OFS_IRQ_ST, 32'h4);
    chk("irq", 0, irq);
    bus(1, cmc_pkg::OFS_BAUD, 32'hFFFF0000);
    rdc("baud", cmc_pkg::OFS_BAUD, 32'h12345678);
    chk("baud_o", 32'h12345678, baud);
    chk("cfg2_o", 32'h4000, cfg);
    chk("filt_o", 32'hA5A50F0F, filt);
    chk("amsk_o", 32'h0000FFFF, amsk);
    tk(1, 0);
    bus(1, cmc_pkg::OFS_TXCTL, 32'h1);
    tk(10, 1);
    chk("starts", 0, starts);
    tk(1, 1);
    chk("starts", 1, starts);
    rdc("txctl", cmc_pkg::OFS_TXCTL, 32'h0);
    busy <= 1;
    bus(1, cmc_pkg::OFS_CTRL1, 32'h400);
    tk(12, 1);
    rdc("ctrl", cmc_pkg::OFS_CTRL1, 32'h400);
    busy <= 0;
    rdc("ctrl", cmc_pkg::OFS_CTRL1, 32'h480);
    bus(1, cmc_pkg::OFS_CTRL1, 32'h0);
    tk(1, 0);
    tk(11, 1);
    tk(1, 0);
    bus(1, cmc_pkg::OFS_TXCTL, 32'h1);
    bus(1, cmc_pkg::OFS_CTRL1, 32'h100);
    rdc("txctl", cmc_pkg::OFS_TXCTL, 32'h2);
    tk(11, 1);
    chk("starts", 1, starts);
    chk("irq", 1, irq);
    rdc("irq_st", cmc_pkg::OFS_IRQ_ST, 32'h6);
    // Short glitch must not pass the wake filter, a long low must
    dom <= 1; repeat (2) @(posedge clk_i);
    dom <= 0; repeat (8) @(posedge clk_i);
    rdc("irq_st", cmc_pkg::OFS_IRQ_ST, 32'h0);
    dom <= 1; repeat (10) @(posedge clk_i);
    dom <= 0; repeat (4) @(posedge clk_i);
    chk("irq", 0, irq);
    rdc("irq_st", cmc_pkg::OFS_IRQ_ST, 32'h1);
    for (int i = 0; i < 6; i++) begin
      bus(1, cmc_pkg::OFS_CTRL1, {21'h0, rows[i][10:8], 8'h00});
      tk(11, 1);
      rdc("mode", cmc_pkg::OFS_CTRL1, {21'h0, rows[i][10:8], rows[i][10:8], 5'h00});
      chk("outs", {24'h0, rows[i][7:0]}, {24'h0, outs});
      if (rows[i][10:8] == 3'h2) begin
        ctx <= 0; repeat (2) @(posedge clk_i);
        chk("loop_rx", 0, crx);
        ctx <= 1;
      end
    end
    give_verdict;
  end
endmodule // tb
`default_nettype wire
